// File: hdl/urx_pkg.sv
// Package of constants and types for the asynchronous receive recovery block.
`default_nettype none
package urx_pkg;
	// ------------------------------------------------------------------
	// Sampling constants and parameter defaults
	// ------------------------------------------------------------------
	localparam logic [4:0] SAMPLES_NORMAL   = 5'h10;
	localparam logic [4:0] SAMPLES_DOUBLE   = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORM  = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DBL   = 5'h04;
	localparam logic [4:0] START_FIRST_NORM = 5'h08;
	localparam logic [4:0] START_FIRST_DBL  = 5'h04;
	localparam int         FRAME_BITS_DEF   = 10;
	localparam int         FIFO_DEPTH_DEF   = 8;
	localparam logic [15:0] BAUD_DIV_DEF    = 16'h0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [9:0] data;
		logic       framing_error_flag;
	} urx_frame_t;

	typedef enum logic [2:0] {
		ST_HUNT  = 3'b001,
		ST_START = 3'b010,
		ST_DATA  = 3'b100
	} urx_state_t;
endpackage
`default_nettype wire

// File: hdl/urx_sync.sv
// Three-stage input synchroniser with agreement filter.
`default_nettype none
module urx_sync
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;

	// Idle line is high, so reset to one avoids a false start edge.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_ff  <= 1'b1;
			s2_ff  <= 1'b1;
			s3_ff  <= 1'b1;
			lvl_ff <= 1'b1;
		end
		else if (ce_i)
		begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				lvl_ff <= s3_ff;
		end
	end

	assign level_o = lvl_ff;
endmodule
`default_nettype wire

// File: hdl/urx_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`default_nettype none
module urx_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
)
(
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial
	begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("urx_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ff;
	logic [AW:0]      rd_ff;
	wire              full_w  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
	wire              empty_w = (wr_ff == rd_ff);
	wire              push_w  = ce_i && in_valid_i && !full_w;
	wire              pop_w   = ce_i && out_ready_i && !empty_w;

	assign in_ready_o  = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o  = mem[rd_ff[AW-1:0]];

	always_ff @(posedge mclk_i)
	begin
		if (push_w)
			mem[wr_ff[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ff <= '0;
			rd_ff <= '0;
		end
		else
		begin
			if (push_w)
				wr_ff <= wr_ff + 1'b1;
			if (pop_w)
				rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: hdl/urx_recovery.sv
// Asynchronous receive clock and data recovery with frame buffer.
//
// Overview of operation
// - Sample at 16x, or 8x in double speed.
// - Falling line edge starts detection, sample one.
// - Vote start on samples 8-10, or 4-6.
// - Majority high rejects start as noise.
// - Valid start realigns bit timing each frame.
// - Per-bit sequence of 16 or 8 states.
// - Data bits decided by three-sample majority.
// - Vote centres at 9 normal, 5 double.
// - Recover through first stop; ignore others.
// - Low first stop sets framing error flag.
// - New start accepted right after stop vote.
// - Sender rate within receiver tolerance limits.
// - Both ends split baud error equally.
// - Framing error buffered with its frame.
`default_nettype none
module urx_recovery
	import urx_pkg::*;
#(
	parameter int FRAME_BITS = urx_pkg::FRAME_BITS_DEF,
	parameter int FIFO_DEPTH = urx_pkg::FIFO_DEPTH_DEF
)
(
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                rxd_i,
	input  wire logic                double_speed_select_i,
	input  wire logic [15:0]         baud_div_i,
	input  wire logic [3:0]          data_bits_i,
	output logic                     frame_valid_o,
	input  wire logic                frame_ready_i,
	output urx_pkg::urx_frame_t      frame_o,
	output logic                     overrun_o,
	output logic                     busy_o
);
	import urx_pkg::*;

	initial
	begin
		if (FRAME_BITS < 5 || FRAME_BITS > 10)
			$error("urx_recovery: FRAME_BITS must be 5 to 10");
	end

	// ------------------------------------------------------------------
	// Baud sample tick
	// ------------------------------------------------------------------
	// Sample tick every baud_div_i+1 system clocks.
	// Exact integer sample period
	logic [15:0] div_ff;
	wire         tick_w = (div_ff == baud_div_i);

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			div_ff <= '0;
		else if (ce_i)
			div_ff <= tick_w ? 16'h0000 : div_ff + 16'h0001;
	end

	// ------------------------------------------------------------------
	// Line synchroniser
	// ------------------------------------------------------------------
	logic line_w;

	urx_sync u_sync
	(
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (rxd_i),
		.level_o (line_w)
	);

	// ------------------------------------------------------------------
	// Mode dependent sample numbers
	// ------------------------------------------------------------------
	// Oversampling rate
	wire [4:0] spb_w     = double_speed_select_i ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
	wire [4:0] st_first_w = double_speed_select_i ? START_FIRST_DBL : START_FIRST_NORM;
	wire [4:0] vt_first_w = double_speed_select_i ? VOTE_FIRST_DBL : VOTE_FIRST_NORM;
	wire [4:0] vt_last_w  = vt_first_w + 5'h02;

	// ------------------------------------------------------------------
	// Recovery state machine
	// ------------------------------------------------------------------
	urx_state_t  state_ff;
	urx_state_t  nxt_state;
	logic [4:0]  smp_ff;
	logic [4:0]  nxt_smp;
	logic [3:0]  bit_ff;
	logic [3:0]  nxt_bit;
	logic [1:0]  votes_ff;
	logic [1:0]  nxt_votes;
	logic [9:0]  shift_ff;
	logic [9:0]  nxt_shift;
	logic        line_d_ff;
	logic        push_ff;
	logic        nxt_push;
	logic        fe_ff;
	logic        nxt_fe;

	wire [3:0] last_bit_w = data_bits_i;
	wire       fall_w     = line_d_ff && !line_w;
	wire       in_vote_w  = (smp_ff >= vt_first_w) && (smp_ff <= vt_last_w);
	wire [1:0] votes_inc_w = votes_ff + {1'b0, line_w};
	wire       maj_w      = votes_inc_w[1];
	wire       vote_end_w = (smp_ff == vt_last_w);
	wire       st_end_w   = (smp_ff == st_first_w + 5'h02);
	wire       bit_end_w  = (smp_ff == spb_w);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_smp   = smp_ff;
		nxt_bit   = bit_ff;
		nxt_votes = votes_ff;
		nxt_shift = shift_ff;
		nxt_push  = 1'b0;
		nxt_fe    = fe_ff;
		case (state_ff)
			ST_HUNT:
			begin
				nxt_votes = 2'h0;
				nxt_smp   = 5'h00;
				if (fall_w)
				begin
					nxt_state = ST_START;
					nxt_smp   = 5'h02;
				end
			end
			ST_START:
			begin
				nxt_smp = smp_ff + 5'h01;
				if ((smp_ff >= st_first_w) && !st_end_w)
					nxt_votes = votes_inc_w;
				if (st_end_w)
				begin
					nxt_votes = 2'h0;
					if (maj_w)
						nxt_state = ST_HUNT;
					else
					begin
						nxt_state = ST_DATA;
						nxt_bit   = 4'h0;
						nxt_fe    = 1'b0;
					end
				end
				if (bit_end_w)
					nxt_smp = 5'h01;
				if (st_end_w && !maj_w)
					nxt_smp = (smp_ff == spb_w) ? 5'h01 : smp_ff + 5'h01;
			end
			default:
			begin
				nxt_smp = bit_end_w ? 5'h01 : smp_ff + 5'h01;
				if (in_vote_w && !vote_end_w)
					nxt_votes = votes_inc_w;
				if (vote_end_w)
				begin
					nxt_votes = 2'h0;
					// Stop bit is the last bit used
					if (bit_ff == last_bit_w)
					begin
						// Low stop bit flags framing error
						nxt_fe    = !maj_w;
						nxt_push  = 1'b1;
						nxt_state = ST_HUNT;
						nxt_smp   = 5'h00;
					end
					else
					begin
						nxt_shift = {maj_w, shift_ff[9:1]};
						nxt_bit   = bit_ff + 4'h1;
					end
				end
			end
		endcase
	end

	// Advances only on sample ticks, so all timing follows the baud clock, except push_ff, which clears on the next enabled clock.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_ff  <= ST_HUNT;
			smp_ff    <= 5'h00;
			bit_ff    <= 4'h0;
			votes_ff  <= 2'h0;
			shift_ff  <= 10'h000;
			line_d_ff <= 1'b1;
			push_ff   <= 1'b0;
			fe_ff     <= 1'b0;
		end
		else if (ce_i)
		begin
			push_ff <= 1'b0;
			if (tick_w)
			begin
				state_ff  <= nxt_state;
				smp_ff    <= nxt_smp;
				bit_ff    <= nxt_bit;
				votes_ff  <= nxt_votes;
				shift_ff  <= nxt_shift;
				line_d_ff <= line_w;
				push_ff   <= nxt_push;
				fe_ff     <= nxt_fe;
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame buffer
	// ------------------------------------------------------------------
	// Right-justify the frame, which arrived LSB first into the top.
	urx_frame_t entry_w;
	logic       in_ready_w;
	logic       ovr_ff;
	wire [3:0]  shamt_w = 4'ha - last_bit_w;

	assign entry_w.data               = shift_ff >> shamt_w;
	assign entry_w.framing_error_flag = fe_ff;

	urx_fifo #(
		.WIDTH ($bits(urx_frame_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo
	(
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (push_ff),
		.in_ready_o  (in_ready_w),
		.in_data_i   (entry_w),
		.out_valid_o (frame_valid_o),
		.out_ready_i (frame_ready_i),
		.out_data_o  (frame_o)
	);

	// A full buffer cannot stall the line, so a lost frame is flagged instead.
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			ovr_ff <= 1'b0;
		else if (ce_i)
		begin
			if (push_ff && !in_ready_w)
				ovr_ff <= 1'b1;
			else if (push_ff)
				ovr_ff <= 1'b0;
		end
	end

	assign overrun_o = ovr_ff;
	assign busy_o    = (state_ff != ST_HUNT);
endmodule
`default_nettype wire

// File: tb/urx_tx_model.sv
// Behavioural far-end serial transmitter for the receive recovery bench.
`default_nettype none
module urx_tx_model
(
	input  wire logic mclk_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial line_o = 1'b1;
	// ------------------
	// Line drivers
	// ------------------
	// exact bit time
	// Callers enter on a clock edge; the line keeps the stop level afterwards.
	task automatic send(input logic [9:0] d, input int nb, input int cpb,
		input logic stp, input int sc);
		line_o <= 1'b0;
		repeat (cpb) @(posedge mclk_i);
		for (int i = 0; i < nb; i++)
		begin
			line_o <= d[i];
			repeat (cpb) @(posedge mclk_i);
		end
		line_o <= stp;
		repeat (sc) @(posedge mclk_i);
	endtask
	task automatic idle(input int n);
		line_o <= 1'b1;
		repeat (n) @(posedge mclk_i);
	endtask
endmodule
`default_nettype wire

// File: tb/urx_recovery_assertions.sv
// Port checks of the receive recovery block.
`default_nettype none
module urx_recovery_checker
	import urx_pkg::*;
#(
	parameter int FRAME_BITS = 10,
	parameter int FIFO_DEPTH = 8
)
(
	input wire logic                mclk_i,
	input wire logic                rst_i,
	input wire logic                rxd_i,
	input wire logic                double_speed_select_i,
	input wire logic [15:0]         baud_div_i,
	input wire logic                frame_valid_o,
	input wire logic                frame_ready_i,
	input wire urx_pkg::urx_frame_t frame_o,
	input wire logic                overrun_o,
	input wire logic                busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_reset_idle:
		assert property (disable iff (1'b0) rst_i |-> !frame_valid_o && !busy_o && !overrun_o)
		else $error("Outputs active in reset.");
	a_hunt_stays_idle:
		assert property ((rxd_i && !busy_o && baud_div_i == 16'h0000)[*8] |=> !busy_o)
		else $error("Left hunting on an idle line.");
	a_noise_reject:
		assert property ($rose(busy_o) ##1 (rxd_i && !double_speed_select_i
			&& baud_div_i == 16'h0000)[*8] |-> ##[1:8] !busy_o)
		else $error("High start votes not rejected.");
	a_frame_bounded:
		assert property ($rose(busy_o) |-> ##[1:400] !busy_o)
		else $error("Busy longer than one frame.");
	a_push_after_stop:
		assert property ($rose(frame_valid_o) |-> $past(busy_o, 2))
		else $error("Frame without a stop vote.");
	a_frame_holds:
		assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_o))
		else $error("Frame changed before pop.");
	a_overrun_full:
		assert property ($rose(overrun_o) |-> frame_valid_o && $past(frame_valid_o))
		else $error("Overrun with empty buffer.");
	a_overrun_clear:
		assert property ($fell(overrun_o) |-> ##[0:1] frame_valid_o)
		else $error("Overrun cleared without frame.");
	cover property ($rose(frame_valid_o) && frame_o.framing_error_flag);
	cover property ($rose(overrun_o));
	cover property ($fell(busy_o) && double_speed_select_i);
endmodule
`default_nettype wire

// File: tb/tb_urx_recovery.sv
// Self-checking testbench of the receive recovery block.
`default_nettype none
module tb_urx_recovery;
	import urx_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        rst_i;
	logic        ce = 1'b1;
	logic        dbl = 1'b0;
	logic [15:0] div = 16'h0000;
	logic [3:0]  nbits = 4'h8;
	logic        rdy = 1'b1;
	logic        line;
	logic        valid;
	logic        ovr;
	logic        busy;
	urx_frame_t  frame;
	urx_frame_t  expq[$];
	int          mismatches = 0;
	int          samples_checked = 0;
	int          cpb = 16;
	int          sc = 10;
	int          esc = 10;
	bit          stall = 1'b0;
	always #25 mclk_i = ~mclk_i;
	urx_tx_model tx (.mclk_i(mclk_i), .line_o(line));
	urx_recovery DUT
	(
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .rxd_i(line),
		.double_speed_select_i(dbl), .baud_div_i(div), .data_bits_i(nbits),
		.frame_valid_o(valid), .frame_ready_i(rdy), .frame_o(frame),
		.overrun_o(ovr), .busy_o(busy)
	);
	// ------------------
	// Checks and frames
	// ------------------
	task automatic chk_frame(input urx_frame_t got, input urx_frame_t exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t: frame %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// A low stop bit is held only through its votes, so no false start follows.
	task automatic frm(input logic stp, input bit keep);
		logic [9:0] d;
		d = 10'($urandom) & ((10'h001 << nbits) - 10'h001);
		if (keep)
			expq.push_back({d, ~stp});
		tx.send(d, int'(nbits), cpb, stp, stp ? sc : esc);
	endtask
	always @(posedge mclk_i)
	begin
		rdy <= !stall && ($urandom_range(3) != 0);
		if (valid === 1'b1 && rdy === 1'b1 && ce === 1'b1)
			chk_frame(frame, expq.size() > 0 ? expq.pop_front() : 'x);
	end
	initial
	begin
		repeat (40000) @(posedge mclk_i);
		mismatches++;
		finish_test();
	end
	// ------------------
	// Scenarios
	// ------------------
	initial
	begin
		rst_i = 1'b1;
		void'($urandom(34361));
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		tx.idle(8);
		stall = 1'b1;
		for (int i = 0; i < 9; i++)
			frm(1'b1, i < 8);
		tx.idle(16);
		chk_flag(ovr, 1'b1);
		ce <= 1'b0;
		stall = 1'b0;
		tx.idle(20);
		chk_flag(valid, 1'b1);
		ce <= 1'b1;
		tx.idle(40);
		chk_flag(valid, 1'b0);
		frm(1'b1, 1'b1);
		tx.idle(20);
		chk_flag(ovr, 1'b0);
		for (int m = 0; m < 3; m++)
		begin
			dbl <= (m > 0);
			div <= 16'(m / 2);
			cpb = (m == 1) ? 8 : 16;
			sc = (m == 0) ? 10 : cpb;
			esc = (m == 0) ? 10 : cpb * 6 / 8;
			tx.idle(4);
			for (int n = 2; n <= cpb / 2; n++)
			begin
				tx.send(10'h000, 0, n, 1'b1, 3 * cpb);
				chk_flag(busy, 1'b0);
			end
			for (int nb = 5; nb <= 9; nb++)
			begin
				nbits <= 4'(nb);
				tx.idle(2);
				repeat (3)
					frm(1'b1, 1'b1);
				frm(1'b0, 1'b1);
				tx.idle(3 * cpb);
			end
		end
		fork
			frm(1'b1, 1'b0);
		join_none
		repeat (60) @(posedge mclk_i);
		rst_i <= 1'b1;
		disable fork;
		tx.idle(3);
		chk_flag(busy, 1'b0);
		rst_i <= 1'b0;
		tx.idle(20);
		frm(1'b1, 1'b1);
		tx.idle(80);
		chk_flag(expq.size() == 0, 1'b1);
		finish_test();
	end
endmodule
bind urx_recovery urx_recovery_checker #(.FRAME_BITS(FRAME_BITS), .FIFO_DEPTH(FIFO_DEPTH)) u_chk
(
	.mclk_i(mclk_i), .rst_i(rst_i), .rxd_i(rxd_i),
	.double_speed_select_i(double_speed_select_i), .baud_div_i(baud_div_i),
	.frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i), .frame_o(frame_o),
	.overrun_o(overrun_o), .busy_o(busy_o)
);
`default_nettype wire
